/* common/rtc_pkg.sv */
// constants and carrier types for the real-time counter and periodic tick block
package rtc_pkg;

  // word index of each register on the avalon bus (byte address = index * 4)
  localparam logic [4:0] OFS_MAIN_CONTROL = 5'h00;
  localparam logic [4:0] OFS_SYNC_STATUS = 5'h01;
  localparam logic [4:0] OFS_IRQ_ENABLE_REGISTER = 5'h02;
  localparam logic [4:0] OFS_IRQ_FLAGS = 5'h03;
  localparam logic [4:0] OFS_DEBUG_CONTROL = 5'h05;
  localparam logic [4:0] OFS_SOURCE_CLOCK_SELECT = 5'h07;
  localparam logic [4:0] OFS_COUNT = 5'h08;
  localparam logic [4:0] OFS_TOP_VALUE_REGISTER = 5'h0A;
  localparam logic [4:0] OFS_COMPARE = 5'h0C;
  localparam logic [4:0] OFS_TICK_CONTROL = 5'h10;
  localparam logic [4:0] OFS_TICK_SYNC_STATUS = 5'h11;
  localparam logic [4:0] OFS_TICK_IRQ_CONTROL = 5'h12;
  localparam logic [4:0] OFS_TICK_IRQ_FLAGS = 5'h13;
  localparam logic [4:0] OFS_TICK_DEBUG_CONTROL = 5'h15;

  // field positions
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned SETTING_LSB = 3;
  localparam int unsigned WRAP_BIT = 0;
  localparam int unsigned MATCH_BIT = 1;

  // reset values
  localparam logic [15:0] TOP_RESET = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] SOURCE_CLOCK_SELECT_RESET = 2'h0;

  // slow edges from a bus write until the value acts
  localparam logic [1:0] SYNC_SLOW_EDGES = 2'h2;

  // synchroniser slots; slots 0 to 3 also give the busy bit order in the status word
  localparam int unsigned NUM_SLOTS = 5;
  localparam int unsigned SLOT_CTRL = 0;
  localparam int unsigned SLOT_COUNT = 1;
  localparam int unsigned SLOT_TOP = 2;
  localparam int unsigned SLOT_COMPARE = 3;
  localparam int unsigned SLOT_TICK = 4;

  // prescaler and tick geometry
  localparam int unsigned PRESC_W = 15;
  localparam int unsigned EVENT_TOP_BIT = 12;
  localparam int unsigned NUM_EVENTS = 8;
  localparam logic [3:0] PERIOD_FIRST = 4'h1;
  localparam logic [3:0] PERIOD_LAST = 4'hE;
  localparam int unsigned NUM_SOURCES = 4;

  typedef struct packed {
    logic [3:0] divider_setting;
    logic counter_enable;
  } main_control_type;

  typedef struct packed {
    logic [3:0] period;
    logic tick_timer_enable;
  } tick_control_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ANSWER = 2'h1
  } bus_state_type;

endpackage : rtc_pkg

/* hdl/rtc_with_periodic_tick.sv */
// real-time counter with periodic tick timer behind an avalon-mm slave
//
// Operation
// - debug halt stops block unless keep-running
// - keep-running bit 1 keeps its own side running
// - one source select feeds counter and tick
// - counter enable 1 starts, 0 stops
// - tick enable starts/stops tick independently
// - divider and interval share one prescaler
// - prescaler held at zero only while both disabled
// - lone tick start: prescaler from zero
// - tick start while counting: phase dependent
// - tick toggles every half interval
// - tick follows one prescaler bit
// - wrap strobe one slow cycle at top
// - compare strobe one slow cycle on match
// - eight square event clocks 8192 down to 64
// - indications on first count after equality
// - divider powers of two, acts two edges later
// - irq while flag and enable both set
// - busy flags while a write crosses over
`timescale 1ns/10ps
`default_nettype none
module rtc_with_periodic_tick (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] slow_clk_i,
  input wire logic debug_halt_i,
  output logic counter_irq_o,
  output logic tick_irq_o,
  output logic wrap_event_o,
  output logic compare_match_o,
  output logic tick_out_o,
  output logic [7:0] tick_events_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state
  rtc_pkg::bus_state_type state_q; // idle or answering
  rtc_pkg::bus_state_type state_d; // next bus state
  logic [31:0] readdata_q; // read word, held for the answer edge

  // software-side registers that act at once
  logic [1:0] irq_enable_q; // wrap and compare enables
  logic [1:0] irq_flags_q; // wrap and compare flags
  logic [1:0] irq_flags_d; // next flags
  logic counter_keep_q; // counter side keeps running in debug
  logic tick_keep_q; // tick side keeps running in debug
  logic [1:0] source_clock_select_q; // slow source select
  logic tick_irq_enable_q; // tick irq enable
  logic tick_flag_q; // tick irq flag
  logic tick_flag_d; // next tick flag

  // registers that cross into slow-edge timing
  logic [1:0] pend_q [rtc_pkg::NUM_SLOTS]; // slow edges still to wait
  logic [15:0] shadow_q [rtc_pkg::NUM_SLOTS]; // written value in flight
  wire logic [4:0] busy; // slot still crossing
  wire logic [4:0] apply; // slot takes effect now
  logic [4:0] wr_slot; // bus write to slot

  // slow-side working state
  rtc_pkg::main_control_type main_control_q; // active counter control
  rtc_pkg::tick_control_type tick_control_q; // active tick control
  logic [15:0] count_q; // the counter
  logic [15:0] top_q; // wrap value
  logic [15:0] compare_q; // compare value
  logic [1:0] strobe_q; // wrap and compare strobes
  logic tick_q; // registered tick level
  logic [7:0] events_q; // registered event clocks

  ////////////////////////////////////////////////////////////////////////////
  // slow timebase edge and shared prescaler
  logic slow_rise; // one cycle per slow rising edge
  logic [14:0] presc; // prescaler count
  logic count_step; // counter advance pulse

  // one selection serves both functions
  slow_edge_detect u_edge (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .slow_clk_i(slow_clk_i),
    .source_clock_select_i(source_clock_select_q),
    .slow_rise_o(slow_rise)
  );

  // debug halt freezes the counter unless its keep-running bit is set, and the tick only while neither running side has its bit set
  wire logic counter_run = main_control_q.counter_enable
                           & (~debug_halt_i | counter_keep_q);
  wire logic tick_run = tick_control_q.tick_timer_enable
                        & (~debug_halt_i | tick_keep_q);

  shared_prescaler u_presc (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .slow_rise_i(slow_rise),
    .counter_enable_i(main_control_q.counter_enable),
    .tick_timer_enable_i(tick_control_q.tick_timer_enable),
    .counter_run_i(counter_run),
    .tick_run_i(tick_run),
    .divider_setting_i(main_control_q.divider_setting),
    .presc_o(presc),
    .count_step_o(count_step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic req = avs_read_i | avs_write_i;
  wire logic answering = (state_q == rtc_pkg::BUS_ANSWER);
  wire logic wr_take = avs_write_i & answering; // write acts at answer edge
  wire logic hit_ctrl = (avs_address_i == rtc_pkg::OFS_MAIN_CONTROL);
  wire logic hit_stat = (avs_address_i == rtc_pkg::OFS_SYNC_STATUS);
  wire logic hit_ien = (avs_address_i == rtc_pkg::OFS_IRQ_ENABLE_REGISTER);
  wire logic hit_flg = (avs_address_i == rtc_pkg::OFS_IRQ_FLAGS);
  wire logic hit_dbg = (avs_address_i == rtc_pkg::OFS_DEBUG_CONTROL);
  wire logic hit_csel = (avs_address_i == rtc_pkg::OFS_SOURCE_CLOCK_SELECT);
  wire logic hit_cnt = (avs_address_i == rtc_pkg::OFS_COUNT);
  wire logic hit_top = (avs_address_i == rtc_pkg::OFS_TOP_VALUE_REGISTER);
  wire logic hit_cmp = (avs_address_i == rtc_pkg::OFS_COMPARE);
  wire logic hit_tctl = (avs_address_i == rtc_pkg::OFS_TICK_CONTROL);
  wire logic hit_tstat = (avs_address_i == rtc_pkg::OFS_TICK_SYNC_STATUS);
  wire logic hit_tien = (avs_address_i == rtc_pkg::OFS_TICK_IRQ_CONTROL);
  wire logic hit_tflg = (avs_address_i == rtc_pkg::OFS_TICK_IRQ_FLAGS);
  wire logic hit_tdbg = (avs_address_i == rtc_pkg::OFS_TICK_DEBUG_CONTROL);

  // register images for readback
  wire logic [15:0] ctrl_img = {9'h000, main_control_q.divider_setting, 2'h0,
                                main_control_q.counter_enable};
  wire logic [15:0] tctl_img = {9'h000, tick_control_q.period, 2'h0,
                                tick_control_q.tick_timer_enable};
  wire logic [15:0] stat_img = {12'h000, busy[3:0]};
  wire logic [15:0] tstat_img = {15'h0000, busy[rtc_pkg::SLOT_TICK]};

  // read mux; unmapped words read zero
  wire logic [15:0] rd_value =
    hit_ctrl ? ctrl_img :
    hit_stat ? stat_img :
    hit_ien ? {14'h0000, irq_enable_q} :
    hit_flg ? {14'h0000, irq_flags_q} :
    hit_dbg ? {15'h0000, counter_keep_q} :
    hit_csel ? {14'h0000, source_clock_select_q} :
    hit_cnt ? count_q :
    hit_top ? top_q :
    hit_cmp ? compare_q :
    hit_tctl ? tctl_img :
    hit_tstat ? tstat_img :
    hit_tien ? {15'h0000, tick_irq_enable_q} :
    hit_tflg ? {15'h0000, tick_flag_q} :
    hit_tdbg ? {15'h0000, tick_keep_q} :
    16'h0000;

  // byte lanes: unselected bytes keep their old content
  wire logic [15:0] be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire logic [15:0] wmerge = (rd_value & ~be_mask) | (avs_writedata_i[15:0] & be_mask);
  wire logic [15:0] w1c = avs_writedata_i[15:0] & be_mask;

  // which synchronised slot a write lands in
  assign wr_slot = {wr_take & hit_tctl, wr_take & hit_cmp, wr_take & hit_top,
                    wr_take & hit_cnt, wr_take & hit_ctrl};

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the answer edge
  always_comb begin
    state_d = rtc_pkg::BUS_IDLE;
    case (state_q)
      rtc_pkg::BUS_IDLE: begin
        // a request is always answered on the following edge
        state_d = req ? rtc_pkg::BUS_ANSWER : rtc_pkg::BUS_IDLE;
      end
      rtc_pkg::BUS_ANSWER: begin
        // master releases after this edge
        state_d = rtc_pkg::BUS_IDLE;
      end
      default: begin
        state_d = rtc_pkg::BUS_IDLE;
      end
    endcase
  end

  // bus state and read capture
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= rtc_pkg::BUS_IDLE;
      readdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (avs_read_i && !answering) begin
        readdata_q <= {16'h0000, rd_value};
      end
    end
  end

  assign avs_waitrequest_o = req & ~answering;
  assign avs_readdata_o = readdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // plain registers that act without crossing
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_enable_q <= 2'h0;
      counter_keep_q <= 1'b0;
      source_clock_select_q <= rtc_pkg::SOURCE_CLOCK_SELECT_RESET;
      tick_irq_enable_q <= 1'b0;
      tick_keep_q <= 1'b0;
    end else if (wr_take) begin
      if (hit_ien) irq_enable_q <= wmerge[1:0];
      if (hit_dbg) counter_keep_q <= wmerge[0];
      if (hit_csel) source_clock_select_q <= wmerge[1:0];
      if (hit_tien) tick_irq_enable_q <= wmerge[0];
      if (hit_tdbg) tick_keep_q <= wmerge[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write crossing: value waits two slow edges, busy meanwhile
  // a second write while busy restarts the wait with the newer value
  genvar g;
  generate
    for (g = 0; g < rtc_pkg::NUM_SLOTS; g++) begin : g_slot
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pend_q[g] <= 2'h0;
          shadow_q[g] <= 16'h0000;
        end else if (wr_slot[g]) begin
          pend_q[g] <= rtc_pkg::SYNC_SLOW_EDGES;
          shadow_q[g] <= wmerge;
        end else if (slow_rise && pend_q[g] != 2'h0) begin
          pend_q[g] <= pend_q[g] - 2'h1;
        end
      end
      assign busy[g] = (pend_q[g] != 2'h0);
      assign apply[g] = slow_rise & (pend_q[g] == 2'h1);
    end
  endgenerate

  // control words as they arrive in the slow timing
  wire logic [15:0] ctrl_new = shadow_q[rtc_pkg::SLOT_CTRL];
  wire logic [15:0] tctl_new = shadow_q[rtc_pkg::SLOT_TICK];

  // active controls, compare and top
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_control_q <= '0;
      tick_control_q <= '0;
      top_q <= rtc_pkg::TOP_RESET;
      compare_q <= rtc_pkg::COMPARE_RESET;
    end else begin
      if (apply[rtc_pkg::SLOT_CTRL]) begin
        main_control_q <= {ctrl_new[rtc_pkg::SETTING_LSB +: 4],
                           ctrl_new[rtc_pkg::ENABLE_BIT]};
      end
      if (apply[rtc_pkg::SLOT_TICK]) begin
        tick_control_q <= {tctl_new[rtc_pkg::SETTING_LSB +: 4],
                           tctl_new[rtc_pkg::ENABLE_BIT]};
      end
      if (apply[rtc_pkg::SLOT_TOP]) top_q <= shadow_q[rtc_pkg::SLOT_TOP];
      if (apply[rtc_pkg::SLOT_COMPARE]) compare_q <= shadow_q[rtc_pkg::SLOT_COMPARE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter: equality is judged on the count that leaves the value
  wire logic wrap_hit = count_step & (count_q == top_q);
  wire logic match_hit = count_step & (count_q == compare_q);

  // count, wrap to zero, or software load
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_q <= rtc_pkg::COUNT_RESET;
    end else if (apply[rtc_pkg::SLOT_COUNT]) begin
      count_q <= shadow_q[rtc_pkg::SLOT_COUNT];
    end else if (wrap_hit) begin
      count_q <= 16'h0000;
    end else if (count_step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // strobes span exactly one slow cycle: set and cleared on slow edges
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_q <= 2'h0;
    end else if (slow_rise) begin
      strobe_q <= {match_hit, wrap_hit};
    end
  end

  assign wrap_event_o = strobe_q[rtc_pkg::WRAP_BIT];
  assign compare_match_o = strobe_q[rtc_pkg::MATCH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // tick: one prescaler bit chosen by the interval code
  wire logic [3:0] period = tick_control_q.period;
  wire logic period_ok = (period >= rtc_pkg::PERIOD_FIRST) &&
                         (period <= rtc_pkg::PERIOD_LAST);
  // code n follows bit n, so the interval is 2^(n+1) slow cycles
  wire logic tick_level = tick_control_q.tick_timer_enable & period_ok
                          & presc[period];
  wire logic tick_rise = tick_level & ~tick_q;

  // event clocks are fixed prescaler bits, zero while the tick is off
  wire logic [7:0] events_d;
  generate
    for (g = 0; g < rtc_pkg::NUM_EVENTS; g++) begin : g_evt
      assign events_d[g] = tick_control_q.tick_timer_enable
                           & presc[rtc_pkg::EVENT_TOP_BIT - g];
    end
  endgenerate

  // registered tick level and event clocks
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_q <= 1'b0;
      events_q <= 8'h00;
    end else begin
      tick_q <= tick_level;
      events_q <= events_d;
    end
  end

  assign tick_out_o = tick_q;
  assign tick_events_o = events_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: write one to clear, a same-cycle set wins
  wire logic [1:0] flag_clr = (wr_take & hit_flg) ? w1c[1:0] : 2'h0;
  wire logic tflag_clr = wr_take & hit_tflg & w1c[0];

  always_comb begin
    irq_flags_d = irq_flags_q & ~flag_clr;
    irq_flags_d[rtc_pkg::WRAP_BIT] = irq_flags_d[rtc_pkg::WRAP_BIT] | wrap_hit;
    irq_flags_d[rtc_pkg::MATCH_BIT] = irq_flags_d[rtc_pkg::MATCH_BIT] | match_hit;
    tick_flag_d = (tick_flag_q & ~tflag_clr) | tick_rise;
  end

  // flag storage
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_flags_q <= 2'h0;
      tick_flag_q <= 1'b0;
    end else begin
      irq_flags_q <= irq_flags_d;
      tick_flag_q <= tick_flag_d;
    end
  end

  // requests stay up until software clears the flag or its enable
  assign counter_irq_o = |(irq_flags_q & irq_enable_q);
  assign tick_irq_o = tick_flag_q & tick_irq_enable_q;

endmodule : rtc_with_periodic_tick
`default_nettype wire

/* hdl/shared_prescaler.sv */
// shared 15-bit prescaler counter with power-of-two counter step
`timescale 1ns/10ps
`default_nettype none
module shared_prescaler (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic slow_rise_i,
  input wire logic counter_enable_i,
  input wire logic tick_timer_enable_i,
  input wire logic counter_run_i,
  input wire logic tick_run_i,
  input wire logic [3:0] divider_setting_i,
  output logic [14:0] presc_o,
  output logic count_step_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [14:0] presc_q;
  // low bits that must all be ones for a counter step
  wire logic [14:0] low_mask = 15'((16'h0001 << divider_setting_i) - 16'h0001);
  wire logic low_full = &(presc_q | ~low_mask);

  // held at zero while both functions are off, so a lone tick start is clean
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_q <= 15'h0000;
    end else if (!counter_enable_i && !tick_timer_enable_i) begin
      presc_q <= 15'h0000;
    end else if (slow_rise_i && (counter_run_i || tick_run_i)) begin
      presc_q <= presc_q + 15'h0001;
    end
  end

  // divide by 2^n: step on the edge that carries the low bits over
  assign count_step_o = slow_rise_i & counter_run_i & low_full;
  assign presc_o = presc_q;

endmodule : shared_prescaler
`default_nettype wire

/* hdl/slow_edge_detect.sv */
// slow timebase source synchronisers, source select and rising-edge pulse
`timescale 1ns/10ps
`default_nettype none
module slow_edge_detect (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] slow_clk_i,
  input wire logic [1:0] source_clock_select_i,
  output logic slow_rise_o
);

  ////////////////////////////////////////////////////////////////////////////
  // two flops per source; only the second stage is ever looked at
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic last_q;
  wire logic chosen = sync_q[source_clock_select_i];

  // a mux behind the synchronisers avoids glitching a raw async select
  genvar g;
  generate
    for (g = 0; g < rtc_pkg::NUM_SOURCES; g++) begin : g_src
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= slow_clk_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  // previous level of the chosen source for edge finding
  // reset high; a source already high at release still gives one edge once it reaches the second stage
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_q <= 1'b1;
    end else begin
      last_q <= chosen;
    end
  end

  assign slow_rise_o = chosen & ~last_q;

endmodule : slow_edge_detect
`default_nettype wire

/* tb/rtc_checker.sv */
// concurrent checks on the counter and tick block ports
`timescale 1ns/10ps
`default_nettype none
module rtc_checker (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic counter_irq_o,
  input wire logic tick_irq_o,
  input wire logic wrap_event_o,
  input wire logic compare_match_o,
  input wire logic tick_out_o,
  input wire logic [7:0] tick_events_o
);
  // widest slow cycle a strobe may span, in sys clocks
  localparam int LONG = 40;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  // one slow cycle high: never under four sys clocks, then gone
  sequence s_strobe(s);
    s [*4] ##[1:LONG] !s;
  endsequence
  property p_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_wrap;
    $rose(wrap_event_o) |-> s_strobe(wrap_event_o);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap strobe length");
  property p_match;
    $rose(compare_match_o) |-> s_strobe(compare_match_o);
  endproperty
  a_match: assert property (p_match) else $error("compare strobe length");
  // requests drop only when software writes
  property p_cirq;
    $fell(counter_irq_o) |-> $past(avs_write_i);
  endproperty
  a_cirq: assert property (p_cirq) else $error("counter irq dropped");
  property p_tirq;
    $fell(tick_irq_o) |-> $past(avs_write_i);
  endproperty
  a_tirq: assert property (p_tirq) else $error("tick irq dropped");
  property p_tflag;
    $rose(tick_irq_o) && !$past(avs_write_i) |-> ##[0:2] tick_out_o;
  endproperty
  a_tflag: assert property (p_tflag) else $error("tick flag without tick");
  // a half interval spans at least two slow cycles, eight sys clocks at the slowest ratio
  property p_half;
    $rose(tick_out_o) |-> tick_out_o [*8];
  endproperty
  a_half: assert property (p_half) else $error("tick high too short");
  property p_event;
    $changed(tick_events_o[7]) |=> $stable(tick_events_o[7]) [*8];
  endproperty
  a_event: assert property (p_event) else $error("event clock too fast");
endmodule : rtc_checker
bind rtc_with_periodic_tick rtc_checker chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .counter_irq_o(counter_irq_o), .tick_irq_o(tick_irq_o), .wrap_event_o(wrap_event_o),
  .compare_match_o(compare_match_o), .tick_out_o(tick_out_o), .tick_events_o(tick_events_o));
`default_nettype wire

/* tb/rtc_with_periodic_tick_tb.sv */
// self-checking bench for the counter and tick block
`timescale 1ns/10ps
`default_nettype none
module rtc_with_periodic_tick_tb;
  logic sys_clk_i, nrst_i, avs_read_i, avs_write_i, debug_halt_i;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, r, q;
  logic [3:0] avs_byteenable_i, slow_clk_i;
  logic avs_waitrequest_o, counter_irq_o, tick_irq_o, wrap_event_o, compare_match_o;
  logic tick_out_o;
  logic [7:0] tick_events_o;
  int n_fail, checks, cyc, sel, n;
  // signal whose rising edges the gap task times
  wire logic mon = sel == 0 ? wrap_event_o : sel == 1 ? tick_out_o :
    sel == 2 ? tick_events_o[7] : !tick_events_o[7];
  rtc_with_periodic_tick dut (.*);
  slow_osc_model partner (.slow_clk_o(slow_clk_i));
  ////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test;
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // compare a seen value with the expected one
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : xfer
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    xfer(1'b0, a, 16'h0000);
  endtask : rd
  // wait until no written value is still crossing over
  task automatic idle;
    do begin
      rd(rtc_pkg::OFS_SYNC_STATUS);
      q = r;
      rd(rtc_pkg::OFS_TICK_SYNC_STATUS);
    end while ((q | r) !== 32'h0000_0000);
  endtask : idle
  // sys clock edges until the watched signal next rises
  task automatic rise;
    logic p;
    n = 0;
    p = 1'b1;
    while (!(mon === 1'b1 && p === 1'b0)) begin
      p = mon;
      @(posedge sys_clk_i);
      n++;
    end
  endtask : rise
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // cut a hang short
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    nrst_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    debug_halt_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(rtc_pkg::OFS_TOP_VALUE_REGISTER);
    check(r, 32'h0000_FFFF, "top reset");
    // unmapped index: write ignored, reads zero
    wr(5'h04, 16'hFFFF);
    rd(5'h04);
    check(r, 32'h0000_0000, "unmapped");
    idle();
    wr(rtc_pkg::OFS_TOP_VALUE_REGISTER, 16'h0003);
    rd(rtc_pkg::OFS_SYNC_STATUS);
    check(r & 32'h0000_0004, 32'h0000_0004, "top busy");
    idle();
    wr(rtc_pkg::OFS_COMPARE, 16'h0001);
    wr(rtc_pkg::OFS_IRQ_ENABLE_REGISTER, 16'h0003);
    // wrap spacing for divide by one and by four
    for (int d = 0; d < 3; d += 2) begin
      idle();
      wr(rtc_pkg::OFS_MAIN_CONTROL, 16'(d * 8 + 1));
      idle();
      sel = 0;
      rise();
      rise();
      check(n, 32 << d, "wrap gap");
    end
    rd(rtc_pkg::OFS_COUNT);
    check(r, 32'h0000_0000, "count after wrap");
    rd(rtc_pkg::OFS_IRQ_FLAGS);
    check(r, 32'h0000_0003, "flags");
    check({31'h0000_0000, counter_irq_o}, 32'h0000_0001, "counter irq");
    wr(rtc_pkg::OFS_IRQ_FLAGS, 16'h0003);
    rd(rtc_pkg::OFS_IRQ_FLAGS);
    check(r, 32'h0000_0000, "flags cleared");
    check({31'h0000_0000, counter_irq_o}, 32'h0000_0000, "counter irq off");
    idle();
    wr(rtc_pkg::OFS_MAIN_CONTROL, 16'h0000);
    idle();
    rd(rtc_pkg::OFS_COUNT);
    q = r;
    repeat (200) @(posedge sys_clk_i);
    rd(rtc_pkg::OFS_COUNT);
    check(r, q, "count held");
    // software load of the count crosses like the other synced words
    idle();
    wr(rtc_pkg::OFS_COUNT, 16'h1234);
    rd(rtc_pkg::OFS_SYNC_STATUS);
    check(r & 32'h0000_0002, 32'h0000_0002, "count busy");
    idle();
    rd(rtc_pkg::OFS_COUNT);
    check(r, 32'h0000_1234, "count load");
    // lone tick start, 16 cycle interval
    wr(rtc_pkg::OFS_TICK_IRQ_CONTROL, 16'h0001);
    idle();
    wr(rtc_pkg::OFS_TICK_CONTROL, 16'h0019);
    sel = 1;
    rise();
    check({31'h0000_0000, n inside {[64:90]}}, 32'h0000_0001, "first tick");
    rise();
    check(n, 128, "tick period");
    check({31'h0000_0000, tick_irq_o}, 32'h0000_0001, "tick irq");
    wr(rtc_pkg::OFS_TICK_IRQ_FLAGS, 16'h0001);
    check({31'h0000_0000, tick_irq_o}, 32'h0000_0000, "tick irq off");
    sel = 2;
    rise();
    sel = 3;
    rise();
    check(n, 256, "event half period");
    // halted without keep-running freezes the tick side
    debug_halt_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    q = {23'h00_0000, tick_events_o, tick_out_o};
    repeat (300) @(posedge sys_clk_i);
    check({23'h00_0000, tick_events_o, tick_out_o}, q, "halted");
    wr(rtc_pkg::OFS_TICK_DEBUG_CONTROL, 16'h0001);
    sel = 1;
    rise();
    rise();
    check(n, 128, "tick in debug");
    debug_halt_i <= 1'b0;
    // second source is half the rate of the first
    wr(rtc_pkg::OFS_SOURCE_CLOCK_SELECT, 16'h0001);
    rise();
    rise();
    check(n, 256, "tick on second source");
    stop_test();
  end
endmodule : rtc_with_periodic_tick_tb
`default_nettype wire

/* tb/slow_osc_model.sv */
// slow timebase sources standing in for the oscillators beside the block
`timescale 1ns/10ps
`default_nettype none
module slow_osc_model #(
  parameter int HALF0 = 40,
  parameter int HALF1 = 80
) (
  output logic [3:0] slow_clk_o
);
  ////////////////////////////////////////
  // free running, phase unrelated to the sys clock edges
  initial slow_clk_o = 4'h0;
  // each source spans at least four sys clocks per cycle
  always #HALF0 slow_clk_o[0] = ~slow_clk_o[0];
  always #HALF1 slow_clk_o[1] = ~slow_clk_o[1];
  always #60 slow_clk_o[2] = ~slow_clk_o[2];
  always #100 slow_clk_o[3] = ~slow_clk_o[3];
endmodule : slow_osc_model
`default_nettype wire
